// File: verilog/lbts_status.sv
/*
 Loopback test control, status and per-lane error count registers.
 Unmapped addresses read zero and ignore writes.
 Assumes the link logic on the core clock supplies training state,
 slave-mode, Loopback.Active entry, TS1 and per-lane error strobes,
 and that requests are held until the done strobe.
*/
`timescale 1ns/100ps
module lbts_status #(
   parameter int TIMEOUT_CYCLES = lbts_pkg::SLAVE_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Configuration access
   input wire lbts_pkg::lbts_cfg_req_s cfgReq,
   output logic [31:0] cfgRdData,
   output logic cfgDoneN,
   // Link state from the core
   input wire logic [5:0] linkTrainingStateCode,
   input wire logic slaveModeIn,
   input wire logic activeEntered,
   input wire logic ts1LoopbackSeen,
   input wire logic [7:0] laneErrorPulse,
   input wire logic [7:0] laneDonePulse,
   // Towards the master state machine
   output lbts_pkg::lbts_ctrl_s ctrlOut,
   output logic masterMode
);
   // =====================================================
   // Internal state
   localparam int TIMER_W = lbts_pkg::TIMER_WIDTH;
   // Terminal count of the slave response timer
   localparam logic [TIMER_W-1:0] TIMER_LAST =
      TIMER_W'(TIMEOUT_CYCLES - 1);
   lbts_pkg::lbts_ctrl_s ctrl;
   lbts_pkg::lbts_state_e state;
   lbts_pkg::lbts_state_e next_state;
   logic acked;
   logic slaveMode;
   logic slaveFailed;
   logic [TIMER_W-1:0] timer;

   // =====================================================
   // Request handshake
   // A held request is taken once, then ignored until released
   wire logic reqActive = ~cfgReq.wrEnN | ~cfgReq.rdEnN;
   wire logic accept = reqActive & ~acked & cfgDoneN;

   // =====================================================
   // Access decode
   wire logic [9:0] baseDw = lbts_pkg::CAP_BASE[11:2];
   wire logic hitCtrl =
      cfgReq.dwAddr == baseDw + 10'(lbts_pkg::OFS_CTRL[11:2]);
   wire logic hitStatus =
      cfgReq.dwAddr == baseDw + 10'(lbts_pkg::OFS_STATUS[11:2]);
   wire logic hitErrLow =
      cfgReq.dwAddr == baseDw + 10'(lbts_pkg::OFS_ERR_LOW[11:2]);
   wire logic hitErrHigh =
      cfgReq.dwAddr == baseDw + 10'(lbts_pkg::OFS_ERR_HIGH[11:2]);
   // Only byte 0 of the control register is writable
   wire logic ctrlWrite =
      accept & ~cfgReq.wrEnN & hitCtrl & ~cfgReq.byteEnN[0];
   wire logic startWrite =
      ctrlWrite & cfgReq.wrData[lbts_pkg::CTRL_START_BIT];
   wire lbts_pkg::lbts_ctrl_s next_ctrl = ctrlWrite ?
      lbts_pkg::lbts_ctrl_s'(cfgReq.wrData[lbts_pkg::CTRL_WIDTH-1:0]) : ctrl;

   // =====================================================
   // Master sequencing
   // Error and done strobes count only while testing
   wire logic inTest = (state == lbts_pkg::ST_WAIT_TS1) |
      (state == lbts_pkg::ST_ACTIVE);
   // A TS1 in the terminal cycle still counts as an answer
   wire logic timeout = (state == lbts_pkg::ST_WAIT_TS1) &
      (timer == TIMER_LAST) & ~ts1LoopbackSeen;
   wire logic failSet = timeout & ~ctrl.forceLoop;
   // Start is refused while the port is a loopback slave
   wire logic linkInL0 = (linkTrainingStateCode == lbts_pkg::LTSSM_L0);
   wire logic startOk = ctrl.start & ~slaveMode & linkInL0;

   always_comb begin
      next_state = state;
      case (state)
         lbts_pkg::ST_IDLE: begin
            // Force alone does nothing; start is required
            if (startOk) begin
               next_state = lbts_pkg::ST_MASTER;
            end
         end
         lbts_pkg::ST_MASTER: begin
            if (activeEntered) begin
               next_state = lbts_pkg::ST_WAIT_TS1;
            end
         end
         lbts_pkg::ST_WAIT_TS1: begin
            if (ts1LoopbackSeen || timeout) begin
               next_state = lbts_pkg::ST_ACTIVE;
            end
         end
         lbts_pkg::ST_ACTIVE: begin
            next_state = lbts_pkg::ST_ACTIVE;
         end
         default: begin
            next_state = lbts_pkg::ST_IDLE;
         end
      endcase
      if (!ctrl.start) begin
         next_state = lbts_pkg::ST_IDLE;
      end
   end

   // Timer runs only while waiting for the slave
   wire logic [TIMER_W-1:0] next_timer =
      (state == lbts_pkg::ST_WAIT_TS1) ? timer + 1'b1 : '0;
   // Failure set wins over the clear by a start write
   wire logic next_failed = failSet | (slaveFailed & ~startWrite);

   // =====================================================
   // Lane counters
   logic [lbts_pkg::CNT_WIDTH-1:0] laneCount [lbts_pkg::LANES];
   logic [lbts_pkg::LANES-1:0] laneTested;
   wire logic [63:0] countsShown;

   genvar lane;
   generate
      for (lane = 0; lane < lbts_pkg::LANES; lane++) begin : g_lane
         lbts_lane_counter u_counter (
            .sys_clk(sys_clk),
            .reset(reset),
            .clearAll(startWrite),
            .counting(inTest),
            .errorPulse(laneErrorPulse[lane]),
            .donePulse(laneDonePulse[lane]),
            .count(laneCount[lane]),
            .tested(laneTested[lane])
         );
         // Untested lanes read zero
         assign countsShown[lane*8 +: 8] = laneTested[lane] ?
            laneCount[lane] : lbts_pkg::CNT_RESET;
      end
   endgenerate

   // =====================================================
   // Read data
   wire logic [31:0] statusWord = {
      16'h0000,
      laneTested,
      6'h00,
      slaveFailed,
      slaveMode
   };
   wire logic [31:0] ctrlWord = {25'h0000000, ctrl};
   wire logic [31:0] errLowWord = countsShown[31:0];
   wire logic [31:0] errHighWord = countsShown[63:32];
   // Unmapped and reserved addresses read zero
   wire logic [31:0] readMux =
      hitCtrl ? ctrlWord :
      hitStatus ? statusWord :
      hitErrLow ? errLowWord :
      hitErrHigh ? errHighWord :
      32'h00000000;
   wire logic rdAccept = accept & ~cfgReq.rdEnN;
   // Read data stands until the next read is taken
   wire logic [31:0] next_rdData = rdAccept ? readMux : cfgRdData;
   wire logic next_doneN = ~accept;
   wire logic next_acked = reqActive & (acked | ~cfgDoneN);

   // =====================================================
   // Control register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl <= lbts_pkg::CTRL_RESET;
         ctrlOut <= lbts_pkg::CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
         ctrlOut <= next_ctrl;
      end
   end

   // =====================================================
   // Sequencer and response timer
   wire logic next_masterMode = (next_state != lbts_pkg::ST_IDLE);
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= lbts_pkg::ST_IDLE;
         masterMode <= 1'b0;
         timer <= '0;
      end else begin
         state <= next_state;
         masterMode <= next_masterMode;
         timer <= next_timer;
      end
   end

   // =====================================================
   // Status flags
   wire logic next_slaveMode = slaveModeIn;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         slaveMode <= 1'b0;
         slaveFailed <= 1'b0;
      end else begin
         slaveMode <= next_slaveMode;
         slaveFailed <= next_failed;
      end
   end

   // =====================================================
   // Bus response
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfgRdData <= 32'h00000000;
         cfgDoneN <= 1'b1;
         acked <= 1'b0;
      end else begin
         cfgRdData <= next_rdData;
         cfgDoneN <= next_doneN;
         acked <= next_acked;
      end
   end
endmodule

// File: verilog/lbts_pkg.sv
/*
 Constants, register map and carrier types of the loopback test status block.
 Assumes a single core clock and the core's dword configuration access port.
*/
// What this block does
// - Status bit 0 shows loopback slave mode
// - Master sets slave-failed after 100 ms silence
// - Slave-failed never set while force is one
// - Writing start one clears slave-failed, unless a timeout sets it in that cycle
// - Writing start one clears lane-tested flags, except a lane whose test completes in that cycle
// - Lane-tested flag set when lane test completes
// - First count register holds lanes 0-3
// - Second count register holds lanes 4-7
// - Count code and disparity errors per lane
// - Writing start one zeroes every count, except a lane with an error counted in that cycle, which loads one
// - Untested lanes read a zero count
// - Start cleared leaves master mode
package lbts_pkg;
   // =====================================================
   // Register map (byte offsets inside the capability)
   localparam logic [11:0] CAP_BASE = 12'h10C;
   localparam logic [11:0] OFS_CTRL = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_ERR_LOW = 12'h010;
   localparam logic [11:0] OFS_ERR_HIGH = 12'h014;
   // =====================================================
   // Field positions and reset values
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_FORCE_BIT = 1;
   localparam int CTRL_WIDTH = 7;
   localparam int STAT_SLAVE_BIT = 0;
   localparam int STAT_FAILED_BIT = 1;
   localparam int STAT_TESTED_LSB = 8;
   localparam int LANES = 8;
   localparam int CNT_WIDTH = 8;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;
   localparam logic [CNT_WIDTH-1:0] CNT_RESET = 8'h00;
   localparam logic [CNT_WIDTH-1:0] CNT_MAX = 8'hFF;
   localparam logic [5:0] LTSSM_L0 = 6'h16;
   // =====================================================
   // Timing
   localparam longint CLK_HZ = 40000000;
   localparam longint SLAVE_TIMEOUT_MS = 100;
   localparam int SLAVE_TIMEOUT_CYCLES =
      int'(CLK_HZ / 1000 * SLAVE_TIMEOUT_MS);
   localparam int TIMER_WIDTH = 23;
   // =====================================================
   // Types
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_MASTER = 4'h2,
      ST_WAIT_TS1 = 4'h4,
      ST_ACTIVE = 4'h8
   } lbts_state_e;
   typedef struct packed {
      logic suppressSkp;
      logic modCompliance;
      logic deemphasis;
      logic [1:0] linkSpeed;
      logic forceLoop;
      logic start;
   } lbts_ctrl_s;
   typedef struct packed {
      logic [9:0] dwAddr;
      logic [31:0] wrData;
      logic [3:0] byteEnN;
      logic wrEnN;
      logic rdEnN;
   } lbts_cfg_req_s;
endpackage

// File: verilog/lbts_lane_counter.sv
/*
 One lane's saturating error counter with its tested flag.
 Assumes strobes come from logic on the same core clock.
*/
`timescale 1ns/100ps
module lbts_lane_counter (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Control
   input wire logic clearAll,
   input wire logic counting,
   input wire logic errorPulse,
   input wire logic donePulse,
   // Results
   output logic [lbts_pkg::CNT_WIDTH-1:0] count,
   output logic tested
);
   wire logic countHit = counting & errorPulse;
   wire logic atMax = (count == lbts_pkg::CNT_MAX);
   wire logic [lbts_pkg::CNT_WIDTH-1:0] next_count =
      clearAll ? (countHit ? 8'h01 : lbts_pkg::CNT_RESET)
      : (countHit && !atMax) ? count + 8'h01 : count;
   // Done strobe wins over a simultaneous clear
   wire logic next_tested = (counting & donePulse) | (tested & ~clearAll);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count <= lbts_pkg::CNT_RESET;
         tested <= 1'b0;
      end else begin
         count <= next_count;
         tested <= next_tested;
      end
   end
endmodule

// File: verif/lbts_link_partner.sv
/* Loopback slave model on the link side.
 Assumes masterMode from the status block, same clock. */
`timescale 1ns/100ps
module lbts_link_partner (
   // Clock and commands
   input wire logic sys_clk,
   input wire logic answer,
   input wire logic [7:0] lanes,
   input wire logic [7:0] errs,
   input wire logic [9:0] nErr,
   // Link strobes
   input wire logic masterMode,
   output logic activeEntered = 1'b0,
   output logic ts1LoopbackSeen = 1'b0,
   output logic [7:0] laneErrorPulse = 8'h00,
   output logic [7:0] laneDonePulse = 8'h00
);
   initial forever begin
      @(posedge masterMode);
      repeat (2) @(posedge sys_clk);
      activeEntered <= 1'b1;
      @(posedge sys_clk);
      activeEntered <= 1'b0;
      // Silent slave sends nothing more
      if (answer) begin
         repeat (3) @(posedge sys_clk);
         ts1LoopbackSeen <= 1'b1;
         @(posedge sys_clk);
         ts1LoopbackSeen <= 1'b0;
         laneErrorPulse <= errs;
         repeat (nErr) @(posedge sys_clk);
         laneErrorPulse <= 8'h00;
         laneDonePulse <= lanes;
         @(posedge sys_clk);
         laneDonePulse <= 8'h00;
      end
   end
endmodule

// File: verif/lbts_status_assertions.sv
/* Port checker of the loopback status block.
 Assumes bind to lbts_status, one core clock. */
`timescale 1ns/100ps
module lbts_status_assertions #(
   parameter int TIMEOUT_CYCLES = 20
) (
   // Watched ports
   input wire logic sys_clk,
   input wire logic reset,
   input wire lbts_pkg::lbts_cfg_req_s cfgReq,
   input wire logic [31:0] cfgRdData,
   input wire logic cfgDoneN,
   input wire logic [5:0] linkTrainingStateCode,
   input wire logic slaveModeIn,
   input wire lbts_pkg::lbts_ctrl_s ctrlOut,
   input wire logic masterMode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire ackRd = !cfgDoneN && !cfgReq.rdEnN;
   wire ackWr = !cfgDoneN && !cfgReq.wrEnN && !cfgReq.byteEnN[0];
   wire l0 = linkTrainingStateCode == lbts_pkg::LTSSM_L0;
   sequence fresh_req;
      cfgDoneN && !(cfgReq.wrEnN && cfgReq.rdEnN)
         && $past(cfgReq.wrEnN && cfgReq.rdEnN);
   endsequence
   AST_DONE_AFTER_REQ: assert property (fresh_req |=> !cfgDoneN)
      else $error("done missing after request");
   AST_DONE_PULSE: assert property (!cfgDoneN |=> cfgDoneN)
      else $error("done longer than one cycle");
   AST_CTRL_WRITE: assert property (ackWr && cfgReq.dwAddr == 10'h045
      |=> ctrlOut == $past(cfgReq.wrData[6:0])) else $error("ctrl lost");
   AST_STATUS_READ: assert property (ackRd && cfgReq.dwAddr == 10'h046
      |-> cfgRdData[0] == $past(slaveModeIn, 2)
      && cfgRdData[31:16] == 16'h0000 && cfgRdData[7:2] == 6'h00)
      else $error("status read wrong");
   AST_UNMAPPED: assert property (ackRd && cfgReq.dwAddr > 10'h048
      |-> cfgRdData == 32'h00000000) else $error("unmapped not zero");
   AST_LEAVE_MASTER: assert property (!ctrlOut.start
      |-> ##[0:2] !masterMode) else $error("master kept");
   AST_ENTER_MASTER: assert property ((ctrlOut.start && l0
      && !slaveModeIn) [*3] |-> ##[0:2] masterMode)
      else $error("master not entered");
   AST_MASTER_GATE: assert property ($rose(masterMode) |->
      $past(ctrlOut.start) && !$past(slaveModeIn, 2) && $past(l0))
      else $error("master without cause");
endmodule
bind lbts_status lbts_status_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
   i_chk (.sys_clk(sys_clk), .reset(reset), .cfgReq(cfgReq),
   .cfgRdData(cfgRdData), .cfgDoneN(cfgDoneN), .masterMode(masterMode),
   .linkTrainingStateCode(linkTrainingStateCode), .ctrlOut(ctrlOut),
   .slaveModeIn(slaveModeIn));

// File: verif/link_loopback_test_status_tb.sv
/* Self-checking bench of the loopback status block.
 Assumes the link partner model and the bound checker. */
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   num_errors++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module link_loopback_test_status_tb;
   logic sys_clk = 0;
   logic reset = 1;
   lbts_pkg::lbts_cfg_req_s cfgReq = 48'h00000000003F;
   logic [31:0] cfgRdData, rd;
   logic cfgDoneN, masterMode, activeEntered, ts1Seen, answer = 0;
   logic [5:0] ltCode = 6'h00;
   logic slaveModeIn = 0;
   logic [7:0] laneErr, laneDone, lanes = 8'h00, errs = 8'h00;
   logic [9:0] nErr = 10'h001;
   lbts_pkg::lbts_ctrl_s ctrlOut;
   int num_errors = 0, check_count = 0, cycles = 0;
   always #12.5 sys_clk = ~sys_clk;
   lbts_status #(.TIMEOUT_CYCLES(20)) i_dut (.sys_clk(sys_clk),
      .reset(reset), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
      .cfgDoneN(cfgDoneN), .linkTrainingStateCode(ltCode),
      .slaveModeIn(slaveModeIn), .activeEntered(activeEntered),
      .ts1LoopbackSeen(ts1Seen), .laneErrorPulse(laneErr),
      .laneDonePulse(laneDone), .ctrlOut(ctrlOut), .masterMode(masterMode));
   lbts_link_partner i_slave (.sys_clk(sys_clk), .answer(answer),
      .lanes(lanes), .errs(errs), .nErr(nErr), .masterMode(masterMode),
      .activeEntered(activeEntered), .ts1LoopbackSeen(ts1Seen),
      .laneErrorPulse(laneErr), .laneDonePulse(laneDone));
   task automatic acc(input logic w, input logic [9:0] a,
         input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge sys_clk);
      cfgReq <= {a, d, be, ~w, w};
      do begin
         @(posedge sys_clk);
         n++;
      end while (cfgDoneN !== 1'b0 && n < 20);
      if (n == 20) num_errors++;
      rd = cfgRdData;
      cfgReq <= 48'h00000000003F;
   endtask
   task automatic rdw(input logic [9:0] a);
      acc(1'b0, a, 32'h00000000, 4'hF);
   endtask
   task automatic wr(input logic [31:0] d);
      acc(1'b1, 10'h045, d, 4'h0);
   endtask
   task automatic run(input logic an, input logic [7:0] ln, er,
         input logic [9:0] n, input logic [31:0] c);
      answer <= an;
      lanes <= ln;
      errs <= er;
      nErr <= n;
      wr(c);
      repeat (300) @(posedge sys_clk);
   endtask
   task automatic t_regs;
      for (int a = 10'h045; a <= 10'h049; a++) begin
         rdw(a[9:0]);
         `CHK(rd, 32'h00000000)
      end
      acc(1'b1, 10'h046, 32'hFFFFFFFF, 4'h0);
      rdw(10'h046);
      `CHK(rd, 32'h00000000)
      acc(1'b1, 10'h045, 32'h0000007C, 4'h1);
      rdw(10'h045);
      `CHK(rd, 32'h00000000)
      wr(32'hFFFFFF7C);
      rdw(10'h045);
      `CHK(rd, 32'h0000007C)
   endtask
   task automatic t_gate;
      answer <= 1'b1;
      wr(32'h00000001);
      repeat (10) @(posedge sys_clk);
      `CHK(masterMode, 1'b0)
      ltCode <= lbts_pkg::LTSSM_L0;
      repeat (3) @(posedge sys_clk);
      `CHK(masterMode, 1'b1)
      wr(32'h00000000);
      repeat (3) @(posedge sys_clk);
      `CHK(masterMode, 1'b0)
      slaveModeIn <= 1'b1;
      rdw(10'h046);
      `CHK(rd, 32'h00000001)
      slaveModeIn <= 1'b0;
   endtask
   task automatic t_test;
      run(1'b1, 8'h0F, 8'h05, 10'h003, 32'h00000001);
      rdw(10'h046);
      `CHK(rd, 32'h00000F00)
      rdw(10'h047);
      `CHK(rd, 32'h00030003)
      rdw(10'h048);
      `CHK(rd, 32'h00000000)
      wr(32'h00000001);
      rdw(10'h046);
      `CHK(rd, 32'h00000000)
      rdw(10'h047);
      `CHK(rd, 32'h00000000)
      wr(32'h00000000);
      run(1'b1, 8'h80, 8'h80, 10'h104, 32'h00000001);
      rdw(10'h048);
      `CHK(rd, 32'hFF000000)
      wr(32'h00000000);
   endtask
   task automatic t_fail;
      run(1'b0, 8'h00, 8'h00, 10'h001, 32'h00000001);
      rdw(10'h046);
      `CHK(rd, 32'h00000002)
      wr(32'h00000001);
      rdw(10'h046);
      `CHK(rd, 32'h00000000)
      wr(32'h00000000);
      run(1'b0, 8'h00, 8'h00, 10'h001, 32'h00000003);
      rdw(10'h046);
      `CHK(rd, 32'h00000000)
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs();
      t_gate();
      t_test();
      t_fail();
      tally_and_finish();
   end
endmodule
